// ===== hw/rbt_defines.vh
// Register offsets, command codes and timing counts for the bit port
`ifndef RBT_DEFINES_VH
`define RBT_DEFINES_VH
`define RBT_OFS_CHIP_STATE   8'h00
`define RBT_OFS_PROTOCOL     8'h01
`define RBT_OFS_IRQ_CAUSE    8'h0c
`define RBT_OFS_IRQ_MASK     8'h0d
`define RBT_OFS_SPECIAL_ONE  8'h10
`define RBT_RST_CHIP_STATE   8'h01
`define RBT_RST_PROTOCOL     8'h02
`define RBT_RST_IRQ_MASK     8'h3e
`define RBT_RST_SPECIAL_ONE  8'h00
`define RBT_CMD_STOP_DECODE  8'h96
`define RBT_SPECIAL_ARM_BIT  3
`define RBT_CHIP_DIRECT_BIT  6
`define RBT_CHIP_RF_BIT      5
`define RBT_CAUSE_TX_BIT     7
`define RBT_BIT_TIME_NS      9440
`define RBT_CLK_PERIOD_NS    100
`define RBT_BIT_HALF_CYC     ((`RBT_BIT_TIME_NS / 2) / `RBT_CLK_PERIOD_NS)
`endif

// ===== hw/rbt_fifo.v
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module rbt_fifo #(
   parameter WIDTH = 1,
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire             clock_in,    // System clock
   input  wire             rst_n_in,    // Async reset, active low
   input  wire [WIDTH-1:0] wr_data_in,  // Write data
   input  wire             wr_valid_in, // Write request
   output wire             wr_ready_out,// Space available
   output reg  [WIDTH-1:0] rd_data_out, // Head word
   output wire             rd_valid_out,// Head valid
   input  wire             rd_ready_in  // Consumer takes head
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0]      wr_ptr;
   reg [AW:0]      rd_ptr;
   wire            full;
   wire            empty;
   wire            do_wr;
   wire            do_rd;
   assign full = (wr_ptr[AW] != rd_ptr[AW]) &&
                 (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
   assign empty = (wr_ptr == rd_ptr);
   assign wr_ready_out = ~full;
   assign rd_valid_out = ~empty;
   assign do_wr = wr_valid_in & ~full;
   assign do_rd = rd_ready_in & ~empty;
   always @(posedge clock_in) begin
      if (do_wr) begin
         mem[wr_ptr[AW-1:0]] <= wr_data_in;
      end
   end
   always @* begin
      rd_data_out = mem[rd_ptr[AW-1:0]];
   end
   always @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wr_ptr <= {(AW+1){1'b0}};
         rd_ptr <= {(AW+1){1'b0}};
      end else begin
         if (do_wr) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (do_rd) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end
endmodule

// ===== hw/rbt_tx_port.v
// Bit-clocked transmit port: SPI register slave, bit clock, bit FIFO
// Summary of operation
// - Pins: enable, data, select, bit clock, MISO, MOSI on I/O 2..7.
// - Stop-decoders command byte 0x96 disables the receive decoders.
// - Reading interrupt cause clears the pending interrupt.
// - Eight further SPI clocks with select low enter transmit mode.
// - With enable high the device pulses bit clock, requesting each bit; the port also holds bit clock low while the bit FIFO is full.
// - Device samples transmit data on bit clock falling edge.
`timescale 1ns/1ps
`include "rbt_defines.vh"
module rbt_tx_port #(
   parameter HALF_CYC   = `RBT_BIT_HALF_CYC,
   parameter FIFO_DEPTH = 16
) (
   input  wire       clock_in,        // System clock, 10 MHz
   input  wire       rst_n_in,        // Async reset, active low
   input  wire       tx_enable_in,    // I/O_2 transmit enable pin
   input  wire       tx_data_in,      // I/O_3 transmit data pin
   input  wire       ss_n_in,         // I/O_4 slave select, active low
   input  wire       sclk_in,         // SPI clock
   input  wire       mosi_in,         // I/O_7 MOSI
   output reg        miso_out,        // I/O_6 MISO
   output reg        bit_clock_out,   // I/O_5 bit clock
   output reg        irq_out,         // Interrupt pin
   output wire [7:0] chip_state_out,  // Chip state control contents
   output wire [7:0] protocol_out,    // Protocol select contents
   output wire       decoders_on_out, // Receive decoders enabled
   output wire       tx_mode_out,     // Bit-clocked transmit mode active
   output wire       enc_valid_out,   // Bit to encoder valid
   output wire       enc_bit_out,     // Bit to encoder
   input  wire       enc_ready_in     // Encoder takes bit
);
   localparam CW = 8;
   localparam S_IDLE = 4'b0001;
   localparam S_CMD  = 4'b0010;
   localparam S_DATA = 4'b0100;
   localparam S_PAD  = 4'b1000;

   // Address bits that the FIFO needs for its depth
   function integer addr_bits;
      input integer depth;
      integer       n;
      begin
         addr_bits = 0;
         for (n = depth - 1; n > 0; n = n >> 1) begin
            addr_bits = addr_bits + 1;
         end
      end
   endfunction
   localparam FIFO_AW = addr_bits(FIFO_DEPTH);

   // Three-stage synchronisers, change counts when stages two and three agree
   reg [2:0] sync_ss;
   reg [2:0] sync_sck;
   reg [2:0] sync_mosi;
   reg [2:0] sync_en;
   reg [2:0] sync_dat;
   reg       ss_n;
   reg       sck;
   reg       mosi;
   reg       en;
   reg       dat;
   reg       sck_d;

   reg [7:0] chip_state;
   reg [7:0] protocol;
   reg [7:0] irq_cause;
   reg [7:0] irq_mask;
   reg [7:0] special_one;
   reg       decoders_on;
   reg       tx_mode;
   reg [3:0] state;
   reg [2:0] bit_cnt;
   reg [7:0] shift_in;
   reg [7:0] shift_out;
   reg [7:0] cmd;
   reg       arm_pending;
   reg [CW-1:0] half_cnt;
   reg       tx_active;
   reg       tx_done_evt;
   reg       bit_take;

   wire      sck_rise;
   wire      sck_fall;
   wire [7:0] rx_byte;
   wire      byte_done;
   wire      bit_fall;
   wire      fifo_wr_ready;

   function [7:0] reg_read;
      input [4:0] ofs;
      begin
         case ({3'b000, ofs})
            `RBT_OFS_CHIP_STATE:  reg_read = chip_state;
            `RBT_OFS_PROTOCOL:    reg_read = protocol;
            `RBT_OFS_IRQ_CAUSE:   reg_read = irq_cause;
            `RBT_OFS_IRQ_MASK:    reg_read = irq_mask;
            `RBT_OFS_SPECIAL_ONE: reg_read = special_one;
            default:              reg_read = 8'h00;
         endcase
      end
   endfunction

   always @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sync_ss   <= 3'b111;
         sync_sck  <= 3'b000;
         sync_mosi <= 3'b000;
         sync_en   <= 3'b000;
         sync_dat  <= 3'b000;
         ss_n      <= 1'b1;
         sck       <= 1'b0;
         mosi      <= 1'b0;
         en        <= 1'b0;
         dat       <= 1'b0;
         sck_d     <= 1'b0;
      end else begin
         sync_ss   <= {sync_ss[1:0], ss_n_in};
         sync_sck  <= {sync_sck[1:0], sclk_in};
         sync_mosi <= {sync_mosi[1:0], mosi_in};
         sync_en   <= {sync_en[1:0], tx_enable_in};
         sync_dat  <= {sync_dat[1:0], tx_data_in};
         if (sync_ss[1] == sync_ss[2]) ss_n <= sync_ss[2];
         if (sync_sck[1] == sync_sck[2]) sck <= sync_sck[2];
         if (sync_mosi[1] == sync_mosi[2]) mosi <= sync_mosi[2];
         if (sync_en[1] == sync_en[2]) en <= sync_en[2];
         if (sync_dat[1] == sync_dat[2]) dat <= sync_dat[2];
         sck_d <= sck;
      end
   end

   assign sck_rise  = sck & ~sck_d;
   assign sck_fall  = ~sck & sck_d;
   assign rx_byte   = {shift_in[6:0], mosi};
   assign byte_done = sck_rise & (bit_cnt == 3'd7) & ~ss_n;

   // SPI slave, mode 0, MSB first: address byte then data bytes
   always @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state       <= S_IDLE;
         bit_cnt     <= 3'd0;
         shift_in    <= 8'h00;
         shift_out   <= 8'h00;
         cmd         <= 8'h00;
         miso_out    <= 1'b0;
         chip_state  <= `RBT_RST_CHIP_STATE;
         protocol    <= `RBT_RST_PROTOCOL;
         irq_mask    <= `RBT_RST_IRQ_MASK;
         special_one <= `RBT_RST_SPECIAL_ONE;
         irq_cause   <= 8'h00;
         decoders_on <= 1'b1;
         arm_pending <= 1'b0;
         tx_mode     <= 1'b0;
      end else begin
         if (sck_rise & ~ss_n) begin
            shift_in <= rx_byte;
            bit_cnt  <= bit_cnt + 3'd1;
         end
         if (sck_fall & ~ss_n) begin
            miso_out  <= shift_out[7];
            shift_out <= {shift_out[6:0], 1'b0};
         end
         // Cause bits: hardware set wins over read clear
         if (byte_done & (state == S_DATA) & cmd[6] &
             (cmd[4:0] == `RBT_OFS_IRQ_CAUSE)) begin
            irq_cause <= {tx_done_evt, 7'h00};
         end else if (tx_done_evt) begin
            irq_cause[`RBT_CAUSE_TX_BIT] <= 1'b1;
         end
         if (ss_n) begin
            bit_cnt <= 3'd0;
            if (state != S_IDLE) state <= S_IDLE;
            arm_pending <= 1'b0;
            tx_mode     <= 1'b0;
         end else begin
            case (state)
               S_IDLE: begin
                  if (!tx_mode) state <= S_CMD;
               end
               S_CMD: begin
                  if (byte_done) begin
                     cmd <= rx_byte;
                     if (rx_byte[7]) begin
                        if (rx_byte == `RBT_CMD_STOP_DECODE) begin
                           decoders_on <= 1'b0;
                        end
                     end else begin
                        state     <= S_DATA;
                        shift_out <= reg_read(rx_byte[4:0]);
                     end
                  end
               end
               S_DATA: begin
                  if (byte_done) begin
                     if (!cmd[6]) begin
                        case ({3'b000, cmd[4:0]})
                           `RBT_OFS_CHIP_STATE: begin
                              chip_state <= rx_byte;
                              // Armed direct bit held open enters pad
                              if (rx_byte[`RBT_CHIP_DIRECT_BIT] &
                                  special_one[`RBT_SPECIAL_ARM_BIT]) begin
                                 arm_pending <= 1'b1;
                                 state       <= S_PAD;
                              end
                           end
                           `RBT_OFS_PROTOCOL:    protocol <= rx_byte;
                           `RBT_OFS_IRQ_MASK:    irq_mask <= rx_byte;
                           `RBT_OFS_SPECIAL_ONE: special_one <= rx_byte;
                           default: ;
                        endcase
                     end
                     cmd[4:0] <= cmd[4:0] + 5'd1;
                     shift_out <= reg_read(cmd[4:0] + 5'd1);
                  end
               end
               S_PAD: begin
                  // Eight dummy clocks complete mode entry
                  if (byte_done & arm_pending) begin
                     tx_mode     <= 1'b1;
                     arm_pending <= 1'b0;
                     state       <= S_IDLE;
                  end
               end
               default: state <= S_IDLE;
            endcase
         end
      end
   end

   // Bit clock generator, runs in transmit mode while transmit enable is high and the FIFO has room
   assign bit_fall = tx_active & bit_clock_out &
                     (half_cnt == HALF_CYC[CW-1:0] - 1'b1);
   always @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         half_cnt      <= {CW{1'b0}};
         bit_clock_out <= 1'b0;
         tx_active     <= 1'b0;
         tx_done_evt   <= 1'b0;
         bit_take      <= 1'b0;
      end else begin
         tx_done_evt <= 1'b0;
         // Synchronised data lags the pin, so take it a clock late
         bit_take    <= bit_fall & fifo_wr_ready;
         if (tx_mode & en & fifo_wr_ready) begin
            tx_active <= 1'b1;
            if (half_cnt == HALF_CYC[CW-1:0] - 1'b1) begin
               half_cnt      <= {CW{1'b0}};
               bit_clock_out <= ~bit_clock_out;
            end else begin
               half_cnt <= half_cnt + 1'b1;
            end
         end else if (!(tx_mode & en)) begin
            if (tx_active) tx_done_evt <= 1'b1;
            tx_active     <= 1'b0;
            half_cnt      <= {CW{1'b0}};
            bit_clock_out <= 1'b0;
         end
      end
   end

   always @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         irq_out <= 1'b0;
      end else begin
         irq_out <= |(irq_cause & ~irq_mask);
      end
   end

   // Sampled bit on falling edge goes to the encoder FIFO
   rbt_fifo #(
      .WIDTH (1),
      .DEPTH (FIFO_DEPTH),
      .AW    (FIFO_AW)
   ) u_fifo (
      .clock_in     (clock_in),
      .rst_n_in     (rst_n_in),
      .wr_data_in   (dat),
      .wr_valid_in  (bit_take),
      .wr_ready_out (fifo_wr_ready),
      .rd_data_out  (enc_bit_out),
      .rd_valid_out (enc_valid_out),
      .rd_ready_in  (enc_ready_in)
   );

   assign chip_state_out  = chip_state;
   assign protocol_out    = protocol;
   assign decoders_on_out = decoders_on;
   assign tx_mode_out     = tx_mode;
endmodule

// ===== verif/rbt_tx_port_assertions.sv
// Pin-level checks for the transmit port
`timescale 1ns/1ps
module rbt_tx_port_chk #(
   parameter HALF_CYC   = 47,
   parameter FIFO_DEPTH = 16
) (
   input logic       clock_in,        // Clock
   input logic       rst_n_in,        // Reset
   input logic       tx_enable_in,    // Enable pin
   input logic       ss_n_in,         // Select
   input logic       bit_clock_out,   // Bit clock
   input logic       irq_out,         // Interrupt
   input logic [7:0] chip_state_out,  // Chip state
   input logic       decoders_on_out, // Decoders on
   input logic       tx_mode_out,     // Mode active
   input logic       enc_valid_out    // Head valid
);
   logic bclk_q;
   int   cnt;
   // Cycles since the last bit clock change
   always @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         bclk_q <= 1'b0;
         cnt    <= 0;
      end else begin
         bclk_q <= bit_clock_out;
         cnt    <= (bit_clock_out != bclk_q) ? 0 : cnt + 1;
      end
   end
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);
   sequence s_rise; $rose(bit_clock_out); endsequence
   sequence s_idle; ss_n_in [*6]; endsequence
   a_low_len: assert property (s_rise |-> cnt >= HALF_CYC - 1)
      else $error("bit clock low phase short");
   a_rise_in_mode: assert property (s_rise |-> tx_mode_out)
      else $error("bit clock outside mode");
   a_idle_no_clk: assert property (!tx_mode_out [*3] |-> !bit_clock_out)
      else $error("bit clock runs without mode");
   a_sample_kept: assert property ($fell(bit_clock_out) && tx_enable_in
      |-> ##[0:2] enc_valid_out) else $error("sampled bit lost");
   a_dec_stay_off: assert property (!decoders_on_out |=> !decoders_on_out)
      else $error("decoders came back on");
   a_dec_off_sel: assert property ($fell(decoders_on_out) |-> !ss_n_in)
      else $error("decoders off without select");
   a_mode_entry: assert property ($rose(tx_mode_out) |->
      !ss_n_in && chip_state_out[6]) else $error("bad mode entry");
   a_mode_exit: assert property (s_idle |-> !tx_mode_out)
      else $error("mode kept after select high");
   a_irq_clear: assert property ($fell(irq_out) |-> !$past(ss_n_in, 2))
      else $error("interrupt cleared without access");
endmodule
bind rbt_tx_port rbt_tx_port_chk #(
   .HALF_CYC(HALF_CYC)
) u_chk (
   .clock_in, .rst_n_in, .tx_enable_in, .ss_n_in, .bit_clock_out,
   .irq_out, .chip_state_out, .decoders_on_out, .tx_mode_out,
   .enc_valid_out
);

// ===== verif/rbt_host_model.sv
// Host controller model: SPI master and bit port driver
`timescale 1ns/1ps
module rbt_host_model (
   input  wire  clock_in,      // Clock
   input  wire  rst_n_in,      // Reset
   input  wire  bit_clock_in,  // Bit clock
   input  wire  miso_in,       // SPI in
   output logic ss_n_out,      // Select
   output logic sclk_out,      // SPI clock
   output logic mosi_out,      // SPI out
   output logic tx_enable_out, // Enable pin
   output logic tx_data_out    // Data pin
);
   int timeouts = 0;
   initial begin
      ss_n_out      = 1'b1;
      sclk_out      = 1'b0;
      mosi_out      = 1'b0;
      tx_enable_out = 1'b1;
      tx_data_out   = 1'b0;
      @(posedge rst_n_in);
      wait_clk(1);
      tx_enable_out = 1'b0;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clock_in);
      #1;
   endtask
   task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
      ss_n_out = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         mosi_out = tx[i];
         wait_clk(6);
         sclk_out = 1'b1;
         rx[i] = miso_in;
         wait_clk(6);
         sclk_out = 1'b0;
      end
   endtask
   task automatic deselect;
      wait_clk(6);
      ss_n_out = 1'b1;
      wait_clk(6);
   endtask
   task automatic wr(input logic [7:0] ofs, dat, input bit hold);
      logic [7:0] r;
      spi_byte(ofs, r);
      spi_byte(dat, r);
      if (!hold) deselect();
   endtask
   task automatic rd(input logic [7:0] ofs, output logic [7:0] dat);
      logic [7:0] r;
      spi_byte(8'h40 | ofs, r);
      spi_byte(8'h00, dat);
      deselect();
   endtask
   // Bounded wait for one bit clock edge
   task automatic wait_bclk(input bit rise);
      fork : wb
         if (rise) @(posedge bit_clock_in);
         else @(negedge bit_clock_in);
         begin
            repeat (100) @(posedge clock_in);
            timeouts++;
         end
      join_any
      disable wb;
      #1;
   endtask
   // No parity: plain bits, LSB first, one per rise
   task automatic send_bits(input logic [15:0] d, input int n);
      tx_enable_out = 1'b1;
      for (int i = 0; i < n; i++) begin
         wait_bclk(1);
         tx_data_out = d[i];
      end
      wait_bclk(0);
   endtask
endmodule

// ===== verif/tb_top.sv
// Self-checking bench for the bit-clocked transmit port
`timescale 1ns/1ps
module tb_top;
   logic       clock_in     = 1'b0;
   logic       rst_n_in     = 1'b0;
   logic       enc_ready_in;
   wire        ss_n, sclk, mosi, miso, tx_en, tx_dat, bclk, irq;
   wire        dec_on, tx_mode, enc_valid, enc_bit;
   wire  [7:0] chip_state, protocol;
   int         fails = 0;
   int         checks = 0;
   int         falls = 0;
   always #50 clock_in = ~clock_in;
   always @(negedge bclk) falls++;
   rbt_tx_port #(.HALF_CYC(4)) DUT (
      .clock_in(clock_in), .rst_n_in(rst_n_in), .tx_enable_in(tx_en),
      .tx_data_in(tx_dat), .ss_n_in(ss_n), .sclk_in(sclk),
      .mosi_in(mosi), .miso_out(miso), .bit_clock_out(bclk),
      .irq_out(irq), .chip_state_out(chip_state),
      .protocol_out(protocol), .decoders_on_out(dec_on),
      .tx_mode_out(tx_mode), .enc_valid_out(enc_valid),
      .enc_bit_out(enc_bit), .enc_ready_in(enc_ready_in));
   rbt_host_model host (
      .clock_in(clock_in), .rst_n_in(rst_n_in), .bit_clock_in(bclk),
      .miso_in(miso), .ss_n_out(ss_n), .sclk_out(sclk),
      .mosi_out(mosi), .tx_enable_out(tx_en), .tx_data_out(tx_dat));
   task automatic check(input string what, input logic [7:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic test_config;
      logic [7:0] r;
      check("decoders", dec_on, 8'h01);
      host.wr(8'h0d, 8'h3e, 0);
      host.wr(8'h01, 8'h88, 0);
      host.wr(8'h00, 8'h21, 0);
      check("protocol", protocol, 8'h88);
      check("chip_state", chip_state, 8'h21);
      host.rd(8'h0d, r);
      check("irq_mask", r, 8'h3e);
      host.rd(8'h05, r);
      check("unmapped", r, 8'h00);
      host.spi_byte(8'h96, r);
      host.deselect();
      check("decoders", dec_on, 8'h00);
      host.rd(8'h0c, r);
      check("irq", irq, 8'h00);
      $display("test_config done");
   endtask
   task automatic test_enter;
      logic [7:0] r;
      host.wr(8'h10, 8'h08, 0);
      host.wr(8'h00, 8'h61, 1);
      check("tx_mode_early", tx_mode, 8'h00);
      host.spi_byte(8'h00, r);
      host.wait_clk(8);
      check("tx_mode", tx_mode, 8'h01);
      $display("test_enter done");
   endtask
   task automatic test_tx;
      logic [15:0] d;
      int f;
      d = 16'h3ca5;
      f = falls;
      host.send_bits(d, 16);
      check("bits_taken", 8'(falls - f), 8'd16);
      f = falls;
      host.wait_clk(40);
      check("stalled", 8'(falls - f), 8'd0);
      host.tx_enable_out = 1'b0;
      host.wait_clk(8);
      check("bclk_idle", bclk, 8'h00);
      check("irq_done", irq, 8'h01);
      enc_ready_in = 1'b1;
      for (int i = 0; i < 16; i++) begin
         #1;
         check("enc_bit", {enc_valid, enc_bit}, {1'b1, d[i]});
         host.wait_clk(1);
      end
      enc_ready_in = 1'b0;
      check("fifo_empty", enc_valid, 8'h00);
      $display("test_tx done");
   endtask
   task automatic test_exit;
      logic [7:0] r;
      host.deselect();
      check("tx_mode_off", tx_mode, 8'h00);
      host.wr(8'h10, 8'h00, 0);
      host.rd(8'h0c, r);
      check("cause", r, 8'h80);
      check("irq_clear", irq, 8'h00);
      host.rd(8'h0c, r);
      check("cause_again", r, 8'h00);
      $display("test_exit done");
   endtask
   task automatic results;
      fails = fails + host.timeouts;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge clock_in);
      fails++;
      results();
   end
   initial begin
      enc_ready_in = 1'b0;
      repeat (10) @(posedge clock_in);
      #1 rst_n_in = 1'b1;
      host.wait_clk(6);
      test_config();
      test_enter();
      test_tx();
      test_exit();
      results();
   end
endmodule
